/* File: hdl/fcsa_assigner.v */
// fifo / internal channel / line channel / pcm slot routing with avalon-mm registers
// assumes inputs synchronous to clk_sys, one clock domain, master holds requests
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fcsa_regs.vh"

module fcsa_assigner #(
   parameter NUM_BITS = 5,
   parameter NFIFO    = 32,
   parameter NSLOT    = 32
) (
   input  wire                clk_sys,
   input  wire                rst,
   input  wire [7:0]          avs_address,
   input  wire                avs_read,
   input  wire                avs_write,
   input  wire [31:0]         avs_writedata,
   input  wire [3:0]          avs_byteenable,
   output reg  [31:0]         avs_readdata,
   output reg                 avs_waitrequest,
   input  wire [NUM_BITS-1:0] slotQueryNum,
   input  wire                slotQueryDir,
   output reg  [NUM_BITS-1:0] slotChanNum_r,
   output reg                 slotChanDir_r,
   output reg                 slotActive_r,
   input  wire [2:0]          lineQueryIf,
   input  wire [1:0]          lineQueryCode,
   input  wire                lineQueryDir,
   output reg                 lineActive_r,
   output reg                 lineReserved_r,
   output reg  [NUM_BITS-1:0] lineFifoNum_r,
   input  wire [NUM_BITS-1:0] chanQueryNum,
   input  wire [NFIFO*8-1:0]  fifoTxData,
   output reg  [7:0]          chanByte_r
);

   // entry counts and index width, an index is {num,dir}
   localparam NENT = 2 * NFIFO;
   localparam NSENT = 2 * NSLOT;
   localparam IDXW = NUM_BITS + 1;

   // ==========================================
   // functions
   // fifo enable test on a connection config entry
   function fifoOn;
      input [6:0] cfg;
      begin
         // either field nonzero enables the entry
         fifoOn = (cfg[`FCSA_CON_TRP_BIT] != 1'b0) ||
                  (cfg[`FCSA_CON_IRQ_MSB:`FCSA_CON_IRQ_LSB] != 3'h0);
      end
   endfunction

   // effective target channel {num,dir} of one fifo entry
   function [IDXW-1:0] effChan;
      input              free_assignment_mode;
      input [IDXW-1:0]   entry;
      input [5:0]        chan;
      begin
         if (free_assignment_mode) begin
            // free mode: programmed channel, reordered to {num,dir}
            effChan = {chan[`FCSA_NUM_MSB:0], chan[`FCSA_DIR_BIT]};
         end else begin
            // simple mode: number and direction of the fifo itself
            effChan = entry;
         end
      end
   endfunction

   // number of unmasked bits in a mask byte
   function [3:0] openBits;
      input [7:0] msk;
      integer k;
      begin
         openBits = 4'h0;
         // every zero mask bit lets one fifo bit through
         for (k = 0; k < 8; k = k + 1) begin
            openBits = openBits + {3'h0, ~msk[k]};
         end
      end
   endfunction

   // ==========================================
   // storage
   reg  [1:0]          mode_r;
   reg  [IDXW-1:0]     fifoSel_r;
   reg  [IDXW-1:0]     slotSel_r;
   reg  [7:0]          fill_r;
   reg  [6:0]          fifoCfg  [0:NENT-1];
   reg  [5:0]          fifoChan [0:NENT-1];
   reg  [7:0]          fifoMask [0:NENT-1];
   reg  [6:0]          slotLink [0:NSENT-1];

   // next values and loop scratch of the combinational processes
   reg  [31:0]         rdData_nxt;
   reg                 slotActive_nxt;
   reg                 lineActive_nxt;
   reg                 lineReserved_nxt;
   reg  [NUM_BITS-1:0] lineFifo_nxt;
   reg  [7:0]          used_nxt;
   reg  [7:0]          bits_nxt;
   reg  [7:0]          chanByte_nxt;
   reg  [IDXW-1:0]     ec;
   reg  [IDXW-1:0]     lineChan;
   reg  [2:0]          fl;
   integer             i;

   // decoded mode, accepted write, current slot link, selected route
   wire csmOn;
   wire seqOn;
   wire wrHit;
   wire [6:0] slotCur;
   wire [IDXW-1:0] selChan;

   // free assignment only when sequence mode is off
   assign csmOn = mode_r[`FCSA_MODE_CSM] & ~mode_r[`FCSA_MODE_SEQ];
   assign seqOn = mode_r[`FCSA_MODE_SEQ];
   assign wrHit = avs_write & ~avs_waitrequest & avs_byteenable[0];
   assign slotCur = slotLink[{slotQueryNum, slotQueryDir}];
   assign selChan = effChan(csmOn, fifoSel_r, fifoChan[fifoSel_r]);

   // ==========================================
   // avalon handshake: one wait cycle, then accept
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else if ((avs_read || avs_write) && avs_waitrequest) begin
         // first sampled request: one ready cycle, read data captured
         avs_waitrequest <= 1'b0;
         avs_readdata    <= rdData_nxt;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // global settings and select pointers
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_r    <= 2'h0;
         fifoSel_r <= {IDXW{1'b0}};
         slotSel_r <= {IDXW{1'b0}};
         fill_r    <= `FCSA_RST_FILL;
      end else if (wrHit) begin
         case (avs_address)
            `FCSA_OFS_MODE: begin
               mode_r <= avs_writedata[1:0];
            end
            `FCSA_OFS_FIFO_SEL: begin
               // selects are kept as {num,dir} entry indexes
               fifoSel_r <= {avs_writedata[`FCSA_NUM_MSB:0], avs_writedata[`FCSA_DIR_BIT]};
            end
            `FCSA_OFS_SLOT_SEL: begin
               slotSel_r <= {avs_writedata[`FCSA_NUM_MSB:0], avs_writedata[`FCSA_DIR_BIT]};
            end
            `FCSA_OFS_FILL: begin
               fill_r <= avs_writedata[7:0];
            end
            default: begin
               fill_r <= fill_r;
            end
         endcase
      end
   end

   // indexed arrays: only the selected entry changes
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (i = 0; i < NENT; i = i + 1) begin
            fifoCfg[i]  <= `FCSA_RST_CFG;
            fifoChan[i] <= `FCSA_RST_CHAN;
            fifoMask[i] <= `FCSA_RST_MASK;
         end
         // slot links start disabled
         for (i = 0; i < NSENT; i = i + 1) begin
            slotLink[i] <= `FCSA_RST_CFG;
         end
      end else if (wrHit) begin
         case (avs_address)
            `FCSA_OFS_FIFO_CON: begin
               fifoCfg[fifoSel_r] <= avs_writedata[6:0];
            end
            `FCSA_OFS_FIFO_CHAN: begin
               fifoChan[fifoSel_r] <= avs_writedata[5:0];
            end
            `FCSA_OFS_FIFO_MASK: begin
               fifoMask[fifoSel_r] <= avs_writedata[7:0];
            end
            `FCSA_OFS_SLOT_LINK: begin
               slotLink[slotSel_r] <= avs_writedata[6:0];
            end
            default: begin
               slotLink[0] <= slotLink[0];
            end
         endcase
      end
   end

   // ==========================================
   // read mux, unmapped reads as zero
   always @* begin
      rdData_nxt = 32'h0000_0000;
      case (avs_address)
         `FCSA_OFS_MODE: begin
            rdData_nxt[1:0] = mode_r;
         end
         `FCSA_OFS_FIFO_SEL: begin
            rdData_nxt[5:0] = {fifoSel_r[0], fifoSel_r[IDXW-1:1]};
         end
         `FCSA_OFS_FIFO_CON: begin
            rdData_nxt[6:0] = fifoCfg[fifoSel_r];
         end
         `FCSA_OFS_FIFO_CHAN: begin
            rdData_nxt[5:0] = fifoChan[fifoSel_r];
         end
         `FCSA_OFS_FIFO_MASK: begin
            rdData_nxt[7:0] = fifoMask[fifoSel_r];
         end
         `FCSA_OFS_SLOT_SEL: begin
            rdData_nxt[5:0] = {slotSel_r[0], slotSel_r[IDXW-1:1]};
         end
         `FCSA_OFS_SLOT_LINK: begin
            rdData_nxt[6:0] = slotLink[slotSel_r];
         end
         `FCSA_OFS_FILL: begin
            rdData_nxt[7:0] = fill_r;
         end
         `FCSA_OFS_RESOLVED: begin
            // resolved route of the selected fifo
            rdData_nxt[`FCSA_NUM_MSB:0] = selChan[IDXW-1:1];
            rdData_nxt[`FCSA_DIR_BIT] = selChan[0];
            rdData_nxt[`FCSA_RES_ACT_BIT] = fifoOn(fifoCfg[fifoSel_r]) & ~seqOn;
            rdData_nxt[`FCSA_RES_CODE_MSB:`FCSA_RES_CODE_LSB] = selChan[2:1];
            rdData_nxt[`FCSA_RES_IF_MSB:`FCSA_RES_IF_LSB] = selChan[5:3];
            // bits per frame: transparent follows mask, framing stays whole
            if (fifoCfg[fifoSel_r][`FCSA_CON_TRP_BIT]) begin
               rdData_nxt[`FCSA_RES_BITS_MSB:`FCSA_RES_BITS_LSB] =
                  openBits(fifoMask[fifoSel_r]);
            end else begin
               rdData_nxt[`FCSA_RES_BITS_MSB:`FCSA_RES_BITS_LSB] = `FCSA_FULL_BYTE;
            end
         end
         default: begin
            rdData_nxt = 32'h0000_0000;
         end
      endcase
   end

   // ==========================================
   // route resolution over all fifo entries
   always @* begin
      slotActive_nxt   = 1'b0;
      lineActive_nxt   = 1'b0;
      lineReserved_nxt = 1'b0;
      lineFifo_nxt     = {NUM_BITS{1'b0}};
      used_nxt         = 8'h00;
      bits_nxt         = 8'h00;
      ec               = {IDXW{1'b0}};
      fl               = 3'h0;
      // line channel number from interface and code
      lineChan = {lineQueryIf, lineQueryCode, lineQueryDir};
      for (i = 0; i < NENT; i = i + 1) begin
         // effective channel and flow code of entry i
         ec = effChan(csmOn, i[IDXW-1:0], fifoChan[i]);
         fl = fifoCfg[i][`FCSA_CON_FLOW_MSB:0];
         if (fifoOn(fifoCfg[i]) && !seqOn) begin
            // slot side: pcm flows match direction, direct flow crosses it
            if (slotCur[`FCSA_LINK_EN_BIT] &&
                ec == {slotCur[`FCSA_NUM_MSB:0], slotCur[`FCSA_DIR_BIT]}) begin
               if (((fl == `FCSA_FLOW_PCM_TX && i[0] == `FCSA_DIR_TX) ||
                    (fl == `FCSA_FLOW_PCM_RX && i[0] != `FCSA_DIR_TX)) &&
                   slotCur[`FCSA_DIR_BIT] == slotQueryDir) begin
                  slotActive_nxt = 1'b1;
               end
               if (fl == `FCSA_FLOW_DIRECT && slotCur[`FCSA_DIR_BIT] != slotQueryDir) begin
                  slotActive_nxt = 1'b1;
               end
            end
            // line side: a fifo or direct coupling owns the line channel
            if (ec == lineChan) begin
               if (fl == `FCSA_FLOW_LINE || fl == `FCSA_FLOW_DIRECT) begin
                  lineActive_nxt = 1'b1;
                  lineFifo_nxt   = i[IDXW-1:1];
               end else if (csmOn) begin
                  lineReserved_nxt = 1'b1;
               end
            end
            // transmit byte of the queried channel from all sharing fifos
            if (ec == {chanQueryNum, `FCSA_DIR_TX} && i[0] == `FCSA_DIR_TX) begin
               bits_nxt = bits_nxt | (fifoTxData[(i/2)*8 +: 8] & ~fifoMask[i]);
               used_nxt = used_nxt | ~fifoMask[i];
            end
         end
      end
      // unused positions come from the fill byte
      chanByte_nxt = bits_nxt | (fill_r & ~used_nxt);
   end

   // ==========================================
   // query answers, one cycle after the inputs
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         slotChanNum_r  <= {NUM_BITS{1'b0}};
         slotChanDir_r  <= 1'b0;
         slotActive_r   <= 1'b0;
         lineActive_r   <= 1'b0;
         lineReserved_r <= 1'b0;
         lineFifoNum_r  <= {NUM_BITS{1'b0}};
         chanByte_r     <= 8'h00;
      end else begin
         slotChanNum_r  <= slotCur[`FCSA_NUM_MSB:0];
         slotChanDir_r  <= slotCur[`FCSA_DIR_BIT];
         slotActive_r   <= slotActive_nxt;
         lineActive_r   <= lineActive_nxt;
         lineReserved_r <= lineReserved_nxt;
         lineFifoNum_r  <= lineFifo_nxt;
         chanByte_r     <= chanByte_nxt;
      end
   end

endmodule
`default_nettype wire

/* File: hdl/fcsa_regs.vh */
// register map, field layout and codes of the fifo/channel/slot assigner
// assumes a 32-bit avalon-mm slave with byte addresses
`ifndef FCSA_REGS_VH
`define FCSA_REGS_VH

// ==========================================
// register byte offsets
`define FCSA_OFS_MODE      8'h00
`define FCSA_OFS_FIFO_SEL  8'h04
`define FCSA_OFS_FIFO_CON  8'h08
`define FCSA_OFS_FIFO_CHAN 8'h0C
`define FCSA_OFS_FIFO_MASK 8'h10
`define FCSA_OFS_SLOT_SEL  8'h14
`define FCSA_OFS_SLOT_LINK 8'h18
`define FCSA_OFS_FILL      8'h1C
`define FCSA_OFS_RESOLVED  8'h20

// ==========================================
// field positions
`define FCSA_MODE_CSM      0
`define FCSA_MODE_SEQ      1
`define FCSA_NUM_MSB       4
`define FCSA_DIR_BIT       5
`define FCSA_LINK_EN_BIT   6
`define FCSA_CON_FLOW_MSB  2
`define FCSA_CON_TRP_BIT   3
`define FCSA_CON_IRQ_LSB   4
`define FCSA_CON_IRQ_MSB   6
`define FCSA_RES_ACT_BIT   6
`define FCSA_RES_CODE_LSB  7
`define FCSA_RES_CODE_MSB  8
`define FCSA_RES_IF_LSB    9
`define FCSA_RES_IF_MSB    11
`define FCSA_RES_BITS_LSB  12
`define FCSA_RES_BITS_MSB  15

// ==========================================
// data flow codes and fixed values
`define FCSA_FLOW_LINE     3'h4
`define FCSA_FLOW_PCM_TX   3'h3
`define FCSA_FLOW_PCM_RX   3'h1
`define FCSA_FLOW_DIRECT   3'h6
`define FCSA_DIR_TX        1'h0
`define FCSA_CH_PER_IF     3'h4
`define FCSA_FULL_BYTE     4'h8
`define FCSA_RST_CFG       7'h00
`define FCSA_RST_CHAN      6'h00
`define FCSA_RST_MASK      8'h00
`define FCSA_RST_FILL      8'hFF

`endif

/* File: testbench/fcsa_far_end.sv */
// far-end model: pcm slot and line channel selection, per-fifo tx bytes
// assumes the bench names a slot, an internal channel and a data seed
`timescale 1ns/1ps
`default_nettype none
module fcsa_far_end (
   input  wire logic         clk_sys,
   input  wire logic [4:0]   wSlot,
   input  wire logic         wSlotDir,
   input  wire logic [4:0]   wChan,
   input  wire logic         wDir,
   input  wire logic [7:0]   seed,
   output var  logic [4:0]   slotQueryNum,
   output var  logic         slotQueryDir,
   output var  logic [2:0]   lineQueryIf,
   output var  logic [1:0]   lineQueryCode,
   output var  logic         lineQueryDir,
   output var  logic [4:0]   chanQueryNum,
   output var  logic [255:0] fifoTxData
);
   // ==========================================
   // selection changes just after the edge
   always @(posedge clk_sys) begin
      slotQueryNum  <= wSlot;
      slotQueryDir  <= wSlotDir;
      lineQueryIf   <= wChan[4:2];
      lineQueryCode <= wChan[1:0];
      lineQueryDir  <= wDir;
      chanQueryNum  <= wChan;
   end
   // ==========================================
   // fifo n offers seed xor n
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         fifoTxData[8*i +: 8] = seed ^ 8'(i);
      end
   end
endmodule
`default_nettype wire

/* File: testbench/fcsa_assigner_properties.sv */
// handshake and query-output checks for the assigner
// assumes one clock clk_sys and async active-high rst
`timescale 1ns/1ps
`default_nettype none
module fcsa_assigner_properties #(
   parameter NUM_BITS = 5,
   parameter NFIFO    = 32
) (
   input wire logic                clk_sys,
   input wire logic                rst,
   input wire logic                avs_read,
   input wire logic                avs_write,
   input wire logic [31:0]         avs_readdata,
   input wire logic                avs_waitrequest,
   input wire logic [NUM_BITS-1:0] slotQueryNum,
   input wire logic                slotQueryDir,
   input wire logic [NUM_BITS-1:0] slotChanNum_r,
   input wire logic                slotActive_r,
   input wire logic [2:0]          lineQueryIf,
   input wire logic [1:0]          lineQueryCode,
   input wire logic                lineQueryDir,
   input wire logic                lineActive_r,
   input wire logic [NUM_BITS-1:0] chanQueryNum,
   input wire logic [NFIFO*8-1:0]  fifoTxData,
   input wire logic [7:0]          chanByte_r
);
   // ==========================================
   // bus handshake
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic quiet;
   // no configuration write taken this cycle
   assign quiet = !(avs_write && !avs_waitrequest);
   a_wait_accept: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("request not answered next cycle");
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_wait_cause: assert property ($fell(avs_waitrequest)
      |-> $past(avs_read || avs_write)) else $error("answer without request");
   a_idle_wait: assert property (!(avs_read || avs_write) && avs_waitrequest
      |=> avs_waitrequest) else $error("answer while idle");
   a_rdata_hold: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
      else $error("readdata moved outside an access");
   // ==========================================
   // query outputs follow only inputs and configuration
   a_slot_hold: assert property (quiet && $past(quiet) && $stable(slotQueryNum)
      && $stable(slotQueryDir) && !$past(rst)
      |=> $stable(slotActive_r) && $stable(slotChanNum_r))
      else $error("slot answer moved");
   a_line_hold: assert property (quiet && $past(quiet) && $stable(lineQueryIf)
      && $stable(lineQueryCode) && $stable(lineQueryDir) && !$past(rst)
      |=> $stable(lineActive_r))
      else $error("line answer moved");
   a_chan_hold: assert property (quiet && $past(quiet) && $stable(chanQueryNum)
      && $stable(fifoTxData) && !$past(rst)
      |=> $stable(chanByte_r)) else $error("channel byte moved");
endmodule
bind fcsa_assigner fcsa_assigner_properties #(.NUM_BITS(NUM_BITS), .NFIFO(NFIFO)) chk (
   .clk_sys(clk_sys), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .slotQueryNum(slotQueryNum), .slotQueryDir(slotQueryDir),
   .slotChanNum_r(slotChanNum_r), .slotActive_r(slotActive_r),
   .lineQueryIf(lineQueryIf), .lineQueryCode(lineQueryCode), .lineQueryDir(lineQueryDir),
   .lineActive_r(lineActive_r), .chanQueryNum(chanQueryNum), .fifoTxData(fifoTxData),
   .chanByte_r(chanByte_r));
`default_nettype wire

/* File: testbench/tb_top.sv */
// self-checking bench for the fifo/channel/slot assigner
// assumes the far-end model drives queries and fifo bytes
`timescale 1ns/1ps
`default_nettype none
`include "fcsa_regs.vh"
module tb_top;
   localparam logic [7:0] MD = `FCSA_OFS_MODE, FS = `FCSA_OFS_FIFO_SEL,
      CN = `FCSA_OFS_FIFO_CON, CH = `FCSA_OFS_FIFO_CHAN, MK = `FCSA_OFS_FIFO_MASK,
      SS = `FCSA_OFS_SLOT_SEL, LK = `FCSA_OFS_SLOT_LINK, FL = `FCSA_OFS_FILL,
      RS = `FCSA_OFS_RESOLVED;
   logic         clk_sys, rst, avs_read, avs_write, avs_waitrequest;
   logic [7:0]   avs_address, seed, chanByte_r;
   logic [31:0]  avs_writedata, avs_readdata, rd, qv;
   logic [3:0]   avs_byteenable;
   logic [4:0]   wSlot, wChan, slotQueryNum, chanQueryNum, slotChanNum_r, lineFifoNum_r;
   logic         wSlotDir, wDir, slotQueryDir, lineQueryDir, slotChanDir_r;
   logic         slotActive_r, lineActive_r, lineReserved_r;
   logic [2:0]   lineQueryIf;
   logic [1:0]   lineQueryCode;
   logic [255:0] fifoTxData;
   int           failCount = 0, nChecks = 0, cyc = 0;
   // packed query answers, fifo number only while active
   assign qv = {10'h0, slotActive_r, slotChanDir_r, slotChanNum_r, lineReserved_r,
      lineActive_r, lineFifoNum_r & {5{lineActive_r}}, chanByte_r};
   fcsa_far_end far (.clk_sys(clk_sys), .wSlot(wSlot), .wSlotDir(wSlotDir), .wChan(wChan),
      .wDir(wDir), .seed(seed), .slotQueryNum(slotQueryNum), .slotQueryDir(slotQueryDir),
      .lineQueryIf(lineQueryIf), .lineQueryCode(lineQueryCode),
      .lineQueryDir(lineQueryDir), .chanQueryNum(chanQueryNum), .fifoTxData(fifoTxData));
   fcsa_assigner DUT (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .slotQueryNum(slotQueryNum),
      .slotQueryDir(slotQueryDir), .slotChanNum_r(slotChanNum_r),
      .slotChanDir_r(slotChanDir_r), .slotActive_r(slotActive_r),
      .lineQueryIf(lineQueryIf), .lineQueryCode(lineQueryCode),
      .lineQueryDir(lineQueryDir), .lineActive_r(lineActive_r),
      .lineReserved_r(lineReserved_r), .lineFifoNum_r(lineFifoNum_r),
      .chanQueryNum(chanQueryNum), .fifoTxData(fifoTxData), .chanByte_r(chanByte_r));
   // ==========================================
   // clock and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failCount++;
         conclude();
      end
   end
   // ==========================================
   // verdict, compare, bus and query tasks
   task automatic conclude();
      if (failCount == 0 && nChecks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      nChecks++;
      if (g !== e) begin
         failCount++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic busOp(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      busOp(1'b1, a, d);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      busOp(1'b0, a, 32'h0);
      chk("readdata", e, rd);
   endtask
   task automatic q(input logic [5:0] s, input logic [5:0] c, input logic [31:0] e);
      @(posedge clk_sys);
      {wSlotDir, wSlot} <= s;
      {wDir, wChan} <= c;
      repeat (3) @(posedge clk_sys);
      chk("query", e, qv);
   endtask
   function automatic logic [31:0] ex(input logic sa, sd, input logic [4:0] sn,
      input logic lr, la, input logic [4:0] lf, input logic [7:0] cb);
      return {10'h0, sa, sd, sn, lr, la, lf, cb};
   endfunction
   // ==========================================
   // main sequence
   initial begin
      rst = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hF;
      {wSlot, wSlotDir, wChan, wDir, seed} = '0;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      q(6'h17, 6'h09, ex(0, 0, 5'd0, 0, 0, 5'd0, 8'hFF));
      rdChk(MD, 32'h0);
      avs_byteenable <= 4'hE;
      wr(FL, 32'h0);
      avs_byteenable <= 4'hF;
      rdChk(FL, 32'hFF);
      wr(8'h40, 32'h1);
      rdChk(8'h40, 32'h0);
      wr(FS, 32'h09);
      wr(CN, 32'h04);
      q(6'h17, 6'h09, ex(0, 0, 5'd0, 0, 0, 5'd0, 8'hFF));
      wr(CN, 32'h0C);
      q(6'h17, 6'h09, ex(0, 0, 5'd0, 0, 1, 5'd9, 8'h09));
      wr(FS, 32'h0D);
      wr(CN, 32'h13);
      wr(SS, 32'h17);
      wr(LK, 32'h4D);
      q(6'h17, 6'h0D, ex(1, 0, 5'd13, 0, 0, 5'd0, 8'h0D));
      q(6'h37, 6'h0D, ex(0, 0, 5'd0, 0, 0, 5'd0, 8'h0D));
      wr(FS, 32'h0C);
      wr(CN, 32'h16);
      wr(FS, 32'h2C);
      wr(CN, 32'h06);
      wr(SS, 32'h16);
      wr(LK, 32'h6C);
      q(6'h16, 6'h0C, ex(0, 1, 5'd12, 0, 1, 5'd12, 8'h0C));
      wr(CN, 32'h16);
      q(6'h16, 6'h0C, ex(1, 1, 5'd12, 0, 1, 5'd12, 8'h0C));
      wr(MD, 32'h1);
      wr(CH, 32'h2C);
      wr(FS, 32'h04);
      wr(CN, 32'h0C);
      wr(MK, 32'hF0);
      wr(FS, 32'h09);
      wr(MK, 32'hFF);
      wr(FS, 32'h0C);
      wr(MK, 32'hFF);
      wr(FS, 32'h0D);
      wr(CH, 32'h15);
      wr(MK, 32'hCF);
      wr(SS, 32'h17);
      wr(LK, 32'h55);
      wr(FL, 32'h5A);
      rdChk(RS, 32'h8AD5);
      seed <= 8'hF0;
      q(6'h17, 6'h15, ex(1, 0, 5'd21, 1, 0, 5'd0, 8'h7A));
      q(6'h16, 6'h00, ex(1, 1, 5'd12, 0, 1, 5'd12, 8'h54));
      wr(FS, 32'h04);
      rdChk(RS, 32'h4040);
      wr(MD, 32'h3);
      q(6'h16, 6'h1F, ex(0, 1, 5'd12, 0, 0, 5'd0, 8'h5A));
      conclude();
   end
endmodule
`default_nettype wire
